// *** rtl/scan_test_regs.sv ***
// test access controller with bypass, identification and boundary scan registers
// Functional notes
// - bypass and boundary registers each selectable between serial in and out.
// - identification register exists, used by identification instruction and reset state.
// - identification register: 32-bit shift stage plus 32-bit latched output.
// - identification selected under its instruction and in logic-reset state.
// - one-bit bypass stage forms path for bypass, clamp, high-impedance.
// - boundary register has shift path and latched output for all cells.
// - 46 cells; bus uses enable cell 1, bit zero 3, interrupt 15, sync 26.
// - codes: bypass 111, extest 000, clamp 011, highz 100, idcode 001.
// - identification: lsb one, 11-bit maker, 16-bit part, 4-bit version.
// - data latches update only on falling clock in update-data state.
`timescale 1ns/100ps
module scan_test_regs #(
  parameter logic [10:0] MFR_CODE = 11'h2aa, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234, // arbitrary value
  parameter logic [3:0] VERSION_CODE = 4'h1 // arbitrary value
) (
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic test_clock, // scan clock pin
  input wire logic test_mode_select, // scan mode select pin
  input wire logic test_serial_in, // scan data in pin
  output logic test_serial_out, // scan data out
  output logic test_serial_out_oe_n, // low while data out driven
  input wire logic [scan_pkg::BSR_LEN-1:0] pin_observe, // pin levels seen by cells
  input wire logic [scan_pkg::BUS_W-1:0] core_bus_data, // functional bus data
  input wire logic [scan_pkg::BUS_W-1:0] core_bus_oe_n, // functional bus enables
  input wire logic core_int, // functional interrupt level
  input wire logic core_int_oe_n, // functional interrupt enable
  input wire logic core_tx_sync, // functional 8 kHz sync
  input wire logic core_tx_sync_oe_n, // functional sync enable
  output logic [scan_pkg::BUS_W-1:0] bus_data_out, // bus pin data
  output logic [scan_pkg::BUS_W-1:0] bus_data_oe_n, // bus pin enables, low drives
  output logic int_out, // interrupt pin data
  output logic int_oe_n, // interrupt enable, low drives
  output logic tx_sync_out, // sync pin data
  output logic tx_sync_oe_n, // sync enable, low drives
  output logic [scan_pkg::ID_W-1:0] id_latched // identification parallel latch
);
  localparam int SW = scan_pkg::BSR_LEN + 3;
  localparam logic [scan_pkg::ID_W-1:0] ID_VALUE =
    {VERSION_CODE, PART_CODE, MFR_CODE, 1'b1};

  logic [SW-1:0] pins_sync;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic [scan_pkg::BSR_LEN-1:0] obs;

  scan_pkg::tap_state_t state_reg;
  scan_pkg::tap_state_t state_next;
  logic [scan_pkg::IR_W-1:0] ir_shift_reg;
  logic [scan_pkg::IR_W-1:0] ir_reg;
  logic [scan_pkg::BSR_LEN-1:0] bsr_shift_reg;
  logic [scan_pkg::BSR_LEN-1:0] bsr_upd_reg;
  logic [scan_pkg::ID_W-1:0] id_shift_reg;
  logic [scan_pkg::ID_W-1:0] id_par_reg;
  logic byp_reg;
  logic tdo_reg;
  logic tdo_oe_n_reg;

  // all pins arrive unsynchronised, the clock pin rides in bit 0
  pin_sampler #(.W(SW)) u_sampler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in({pin_observe, test_serial_in, test_mode_select, test_clock}),
    .pin_sync(pins_sync),
    .clk_rise(tck_rise),
    .clk_fall(tck_fall)
  );
  assign tms = pins_sync[1];
  assign tdi = pins_sync[2];
  assign obs = pins_sync[SW-1:3];

  // register selection from current instruction; identification is also selected in the logic-reset state
  wire sel_id = (ir_reg == scan_pkg::OP_IDCODE) || (state_reg == scan_pkg::ST_RESET);
  wire sel_bsr = (ir_reg == scan_pkg::OP_EXTEST) || (ir_reg == scan_pkg::OP_SAMPLE);
  wire sel_byp = !sel_id && !sel_bsr;
  wire in_shift_dr = (state_reg == scan_pkg::ST_SHIFT_DR);
  wire in_shift_ir = (state_reg == scan_pkg::ST_SHIFT_IR);
  wire dr_lsb = sel_id ? id_shift_reg[0] : (sel_bsr ? bsr_shift_reg[0] : byp_reg);
  wire tdo_next = in_shift_ir ? ir_shift_reg[0] : dr_lsb;
  wire test_drive = (ir_reg == scan_pkg::OP_EXTEST) || (ir_reg == scan_pkg::OP_CLAMP);
  wire test_float = (ir_reg == scan_pkg::OP_HIGHZ);

  // controller transitions on the mode select bit
  always_comb begin
    case (state_reg)
      scan_pkg::ST_RESET: state_next = tms ? scan_pkg::ST_RESET : scan_pkg::ST_IDLE;
      scan_pkg::ST_IDLE: state_next = tms ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
      scan_pkg::ST_SEL_DR: state_next = tms ? scan_pkg::ST_SEL_IR : scan_pkg::ST_CAP_DR;
      scan_pkg::ST_CAP_DR: state_next = tms ? scan_pkg::ST_EXIT1_DR : scan_pkg::ST_SHIFT_DR;
      scan_pkg::ST_SHIFT_DR: state_next = tms ? scan_pkg::ST_EXIT1_DR : scan_pkg::ST_SHIFT_DR;
      scan_pkg::ST_EXIT1_DR: state_next = tms ? scan_pkg::ST_UPD_DR : scan_pkg::ST_PAUSE_DR;
      scan_pkg::ST_PAUSE_DR: state_next = tms ? scan_pkg::ST_EXIT2_DR : scan_pkg::ST_PAUSE_DR;
      scan_pkg::ST_EXIT2_DR: state_next = tms ? scan_pkg::ST_UPD_DR : scan_pkg::ST_SHIFT_DR;
      scan_pkg::ST_UPD_DR: state_next = tms ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
      scan_pkg::ST_SEL_IR: state_next = tms ? scan_pkg::ST_RESET : scan_pkg::ST_CAP_IR;
      scan_pkg::ST_CAP_IR: state_next = tms ? scan_pkg::ST_EXIT1_IR : scan_pkg::ST_SHIFT_IR;
      scan_pkg::ST_SHIFT_IR: state_next = tms ? scan_pkg::ST_EXIT1_IR : scan_pkg::ST_SHIFT_IR;
      scan_pkg::ST_EXIT1_IR: state_next = tms ? scan_pkg::ST_UPD_IR : scan_pkg::ST_PAUSE_IR;
      scan_pkg::ST_PAUSE_IR: state_next = tms ? scan_pkg::ST_EXIT2_IR : scan_pkg::ST_PAUSE_IR;
      scan_pkg::ST_EXIT2_IR: state_next = tms ? scan_pkg::ST_UPD_IR : scan_pkg::ST_SHIFT_IR;
      scan_pkg::ST_UPD_IR: state_next = tms ? scan_pkg::ST_SEL_DR : scan_pkg::ST_IDLE;
      default: state_next = scan_pkg::ST_RESET;
    endcase
  end

  // controller advances on the rising scan clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= scan_pkg::ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // instruction shift and latch; reset state forces identification
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift_reg <= scan_pkg::IR_CAPTURE_VAL;
      ir_reg <= scan_pkg::OP_IDCODE;
    end else begin
      if (tck_rise && state_reg == scan_pkg::ST_CAP_IR) begin
        ir_shift_reg <= scan_pkg::IR_CAPTURE_VAL;
      end else if (tck_rise && in_shift_ir) begin
        ir_shift_reg <= {tdi, ir_shift_reg[scan_pkg::IR_W-1:1]};
      end
      if (state_reg == scan_pkg::ST_RESET) begin
        ir_reg <= scan_pkg::OP_IDCODE;
      end else if (tck_fall && state_reg == scan_pkg::ST_UPD_IR) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // bypass stage: zero on capture, one stage on shift
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_reg <= scan_pkg::BYPASS_CAPTURE;
    end else if (tck_rise && sel_byp && state_reg == scan_pkg::ST_CAP_DR) begin
      byp_reg <= scan_pkg::BYPASS_CAPTURE;
    end else if (tck_rise && sel_byp && in_shift_dr) begin
      byp_reg <= tdi;
    end
  end

  // identification shift stage and its parallel latch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_shift_reg <= ID_VALUE;
      id_par_reg <= ID_VALUE;
    end else begin
      if (tck_rise && sel_id && state_reg == scan_pkg::ST_CAP_DR) begin
        id_shift_reg <= ID_VALUE;
      end else if (tck_rise && sel_id && in_shift_dr) begin
        id_shift_reg <= {tdi, id_shift_reg[scan_pkg::ID_W-1:1]};
      end
      if (tck_fall && sel_id && state_reg == scan_pkg::ST_UPD_DR) begin
        id_par_reg <= id_shift_reg;
      end
    end
  end

  // boundary chain: capture pins, shift, update latches only in update-data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_shift_reg <= '0;
      bsr_upd_reg <= '0;
    end else begin
      if (tck_rise && sel_bsr && state_reg == scan_pkg::ST_CAP_DR) begin
        bsr_shift_reg <= obs;
      end else if (tck_rise && sel_bsr && in_shift_dr) begin
        bsr_shift_reg <= {tdi, bsr_shift_reg[scan_pkg::BSR_LEN-1:1]};
      end
      if (tck_fall && sel_bsr && state_reg == scan_pkg::ST_UPD_DR) begin
        bsr_upd_reg <= bsr_shift_reg;
      end
    end
  end

  // serial out changes on the falling clock so the tester samples it stable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_reg <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end else if (tck_fall) begin
      tdo_reg <= tdo_next;
      tdo_oe_n_reg <= !(in_shift_dr || in_shift_ir);
    end
  end
  assign test_serial_out = tdo_reg;
  assign test_serial_out_oe_n = tdo_oe_n_reg;
  assign id_latched = id_par_reg;

  // pin muxes; a control cell at one enables its drivers
  logic [scan_pkg::BUS_W-1:0] bus_d_next;
  logic [scan_pkg::BUS_W-1:0] bus_oe_next;
  logic [scan_pkg::BUS_W-1:0] bus_data_reg;
  logic [scan_pkg::BUS_W-1:0] bus_oe_n_reg;
  logic int_reg;
  logic int_oe_n_reg;
  logic sync_reg;
  logic sync_oe_n_reg;
  genvar k;
  generate
    for (k = 0; k < scan_pkg::BUS_W; k++) begin : g_bus
      localparam int DC = (k == 0) ? scan_pkg::CELL_BUS0 :
        (k == 1) ? scan_pkg::CELL_BUS1 : scan_pkg::CELL_BUS_TOP_BASE - k;
      localparam int EC = (k == 0) ? scan_pkg::CELL_BUS0_OE : scan_pkg::CELL_BUS_UPPER_OE;
      assign bus_d_next[k] = test_drive ? bsr_upd_reg[DC] : core_bus_data[k];
      assign bus_oe_next[k] = test_float ? 1'b1 :
        (test_drive ? !bsr_upd_reg[EC] : core_bus_oe_n[k]);
    end
  endgenerate
  wire int_next = test_drive ? bsr_upd_reg[scan_pkg::CELL_INT] : core_int;
  wire int_oe_next = test_float ? 1'b1 :
    (test_drive ? !bsr_upd_reg[scan_pkg::CELL_INT_OE] : core_int_oe_n);
  wire sync_next = test_drive ? bsr_upd_reg[scan_pkg::CELL_SYNC] : core_tx_sync;
  wire sync_oe_next = test_float ? 1'b1 :
    (test_drive ? !bsr_upd_reg[scan_pkg::CELL_SYNC_OE] : core_tx_sync_oe_n);

  // pin outputs registered; drivers stay off during reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_reg <= '0;
      bus_oe_n_reg <= '1;
      int_reg <= 1'b0;
      int_oe_n_reg <= 1'b1;
      sync_reg <= 1'b0;
      sync_oe_n_reg <= 1'b1;
    end else begin
      bus_data_reg <= bus_d_next;
      bus_oe_n_reg <= bus_oe_next;
      int_reg <= int_next;
      int_oe_n_reg <= int_oe_next;
      sync_reg <= sync_next;
      sync_oe_n_reg <= sync_oe_next;
    end
  end
  assign bus_data_out = bus_data_reg;
  assign bus_data_oe_n = bus_oe_n_reg;
  assign int_out = int_reg;
  assign int_oe_n = int_oe_n_reg;
  assign tx_sync_out = sync_reg;
  assign tx_sync_oe_n = sync_oe_n_reg;

  // checks on the scan behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_upd_ir;
    tck_fall && state_reg == scan_pkg::ST_UPD_IR;
  endsequence
  sequence s_cap_dr;
    tck_rise && state_reg == scan_pkg::ST_CAP_DR;
  endsequence

  a_reset_selects_id: assert property (state_reg == scan_pkg::ST_RESET |=>
    ir_reg == scan_pkg::OP_IDCODE) else $error("reset state did not force identification");
  a_ir_latch_fall: assert property (s_upd_ir |=> ir_reg == $past(ir_shift_reg))
    else $error("instruction not latched on falling clock");
  a_bypass_zero: assert property (s_cap_dr and sel_byp |=> byp_reg == 1'b0)
    else $error("bypass did not capture zero");
  a_id_capture_val: assert property (s_cap_dr and sel_id |=> id_shift_reg == ID_VALUE)
    else $error("identification value not captured");
  a_id_lsb_one: assert property (s_cap_dr and sel_id |=>
    id_shift_reg[scan_pkg::ID_MARK_BIT] &&
    id_shift_reg[scan_pkg::ID_W-1:scan_pkg::ID_VER_LSB] == VERSION_CODE)
    else $error("identification layout wrong");
  a_bsr_upd_hold: assert property (state_reg != scan_pkg::ST_UPD_DR |=>
    $stable(bsr_upd_reg)) else $error("boundary latch moved outside update");
  a_bsr_shift_step: assert property (tck_rise && sel_bsr && in_shift_dr |=>
    bsr_shift_reg == {$past(tdi), $past(bsr_shift_reg[scan_pkg::BSR_LEN-1:1])})
    else $error("boundary shift wrong");
  a_bypass_path: assert property (tck_fall && in_shift_dr && sel_byp |=>
    tdo_reg == $past(byp_reg) && !tdo_oe_n_reg) else $error("bypass path not on serial out");
  a_highz_float: assert property (test_float ##1 test_float |=> &bus_data_oe_n &&
    int_oe_n && tx_sync_oe_n) else $error("high-impedance not applied");
  // drive mode must hold in the cycle that feeds the pin registers, not only the first
  a_extest_bit0: assert property (test_drive ##1 (test_drive &&
    $stable(bsr_upd_reg)) |=> bus_data_out[0] == $past(bsr_upd_reg[scan_pkg::CELL_BUS0], 2) &&
    tx_sync_oe_n == !$past(bsr_upd_reg[scan_pkg::CELL_SYNC_OE], 2))
    else $error("cell map not driving pins");
endmodule // scan_test_regs

// *** rtl/scan_pkg.sv ***
// constants, cell map and controller states for the boundary-scan test registers
package scan_pkg;
  localparam int IR_W = 3;
  localparam int BSR_LEN = 46;
  localparam int ID_W = 32;
  localparam int BUS_W = 8;

  // instruction codes
  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h2;
  localparam logic [IR_W-1:0] OP_CLAMP = 3'h3;
  localparam logic [IR_W-1:0] OP_HIGHZ = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;

  // identification field positions
  localparam int ID_MARK_BIT = 0;
  localparam int ID_MFR_LSB = 1;
  localparam int ID_PART_LSB = 12;
  localparam int ID_VER_LSB = 28;

  // boundary cell positions
  localparam int CELL_BUS1 = 0;
  localparam int CELL_BUS_UPPER_OE = 1;
  localparam int CELL_BUS0 = 2;
  localparam int CELL_BUS0_OE = 3;
  localparam int CELL_INT = 14;
  localparam int CELL_INT_OE = 15;
  localparam int CELL_SYNC = 25;
  localparam int CELL_SYNC_OE = 26;
  localparam int CELL_BUS_TOP_BASE = 47; // bus bit k (k>=2) sits at cell 47-k

  localparam int SYNC_STAGES = 2;
  localparam logic BYPASS_CAPTURE = 1'b0;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;
endpackage

// *** rtl/pin_sampler.sv ***
// two-flop synchroniser for test pins with edge detection on bit 0
`timescale 1ns/100ps
module pin_sampler #(
  parameter int W = 4
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] pin_in, // asynchronous pin levels
  output logic [W-1:0] pin_sync, // synchronised levels
  output logic clk_rise, // one-cycle pulse, bit 0 rose
  output logic clk_fall // one-cycle pulse, bit 0 fell
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic prev_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg[0];
    end
  end

  // edges of the sampled scan clock
  assign pin_sync = sync_reg;
  assign clk_rise = sync_reg[0] & ~prev_reg;
  assign clk_fall = ~sync_reg[0] & prev_reg;
endmodule // pin_sampler

// *** tb/scan_tester.sv ***
// tester model that drives the scan clock, mode select and serial data in
`timescale 1ns/100ps
module scan_tester (
  input wire logic ref_clk, // bench clock, paces the scan clock
  input wire logic tdo, // device serial out
  input wire logic tdo_oe_n, // device serial out enable, low drives
  output logic tck, // scan clock, still and low between frames
  output logic tms, // mode select
  output logic tdi // serial data in
);
  logic last_v = 1'b0;
  logic x;
  // a released line shows the inverse of its last driven value
  wire logic line_v = tdo_oe_n ? ~last_v : tdo;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  always @(posedge ref_clk) begin
    if (!tdo_oe_n) begin
      last_v <= tdo;
    end
  end
  // one scan clock: 4 ref_clk low, 4 high; tdo read late, it stands to the fall
  task automatic step(input logic ms, input logic di, output logic so);
    tck = 1'b0;
    tms = ms;
    tdi = di;
    repeat (4) @(negedge ref_clk);
    tck = 1'b1;
    repeat (3) @(negedge ref_clk);
    so = line_v;
    @(negedge ref_clk);
  endtask
  task automatic walk(input logic [7:0] ms, input int n);
    for (int i = 0; i < n; i++) begin
      step(ms[i], 1'b0, x);
    end
  endtask
  // final fall, leaving the clock low; the update states latch on the fall of the walk step that leaves them
  task automatic drop();
    tck = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  // lsb first, mode select high on the last bit
  task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
  task automatic ir_scan(input logic [2:0] code, output logic [2:0] cap);
    logic [63:0] o;
    walk(8'h03, 4);
    shift(3, 64'(code), o);
    cap = o[2:0];
    walk(8'h01, 2);
    drop();
  endtask
  // optionally parks in the data pause state
  task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout,
                         input logic pause);
    walk(8'h01, 3);
    shift(n, din, dout);
    if (pause) begin
      walk(8'h00, 1);
    end else begin
      walk(8'h01, 2);
    end
    drop();
  endtask
  task automatic resume();
    walk(8'h03, 3);
    drop();
  endtask
  task automatic tap_reset();
    walk(8'h1f, 6);
    drop();
  endtask
endmodule // scan_tester

// *** tb/tb_top.sv ***
// self-checking bench for the boundary-scan test registers
`timescale 1ns/100ps
module tb_top;
  localparam logic [10:0] MFR = 11'h155; // arbitrary value
  localparam logic [15:0] PART = 16'h5a3c; // arbitrary value
  localparam logic [3:0] VER = 4'h6; // arbitrary value
  localparam logic [31:0] ID = {VER, PART, MFR, 1'b1};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [45:0] pin_obs = '0;
  logic [7:0] cbus = '0;
  logic [7:0] cbus_oe_n = '1;
  logic cint = 1'b0;
  logic cint_oe_n = 1'b1;
  logic csync = 1'b0;
  logic csync_oe_n = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe_n, int_o, int_oe_n, sync_o, sync_oe_n;
  logic [7:0] bus_o;
  logic [7:0] bus_oe_n;
  logic [31:0] id_l;
  logic [45:0] m_bsr = '0;
  logic [2:0] m_ir;
  int err_total = 0;
  int tests_run = 0;
  int unsigned seed_v;
  wire logic [19:0] pins_seen = {bus_o, bus_oe_n, int_o, int_oe_n, sync_o, sync_oe_n};

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  scan_tester tester (.ref_clk(ref_clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck),
    .tms(tms), .tdi(tdi));
  scan_test_regs #(.MFR_CODE(MFR), .PART_CODE(PART), .VERSION_CODE(VER)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .test_clock(tck), .test_mode_select(tms),
    .test_serial_in(tdi), .test_serial_out(tdo), .test_serial_out_oe_n(tdo_oe_n),
    .pin_observe(pin_obs), .core_bus_data(cbus), .core_bus_oe_n(cbus_oe_n),
    .core_int(cint), .core_int_oe_n(cint_oe_n), .core_tx_sync(csync),
    .core_tx_sync_oe_n(csync_oe_n), .bus_data_out(bus_o), .bus_data_oe_n(bus_oe_n),
    .int_out(int_o), .int_oe_n(int_oe_n), .tx_sync_out(sync_o), .tx_sync_oe_n(sync_oe_n),
    .id_latched(id_l));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatched %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // new core values, then pins against the model after the register delay
  task automatic check_pins();
    logic [19:0] e;
    {cbus, cbus_oe_n, cint, cint_oe_n, csync, csync_oe_n} = 20'($urandom);
    repeat (4) @(negedge ref_clk);
    e = {cbus, cbus_oe_n, cint, cint_oe_n, csync, csync_oe_n};
    if (m_ir == 3'h0 || m_ir == 3'h3) begin
      e = {m_bsr[40], m_bsr[41], m_bsr[42], m_bsr[43], m_bsr[44], m_bsr[45], m_bsr[0],
           m_bsr[2], {7{~m_bsr[1]}}, ~m_bsr[3], m_bsr[14], ~m_bsr[15], m_bsr[25], ~m_bsr[26]};
    end
    if (m_ir == 3'h4) begin
      check(64'(pins_seen & 20'h00ff5), 64'h00ff5);
    end else begin
      check(64'(pins_seen), 64'(e));
    end
  endtask

  // watchdog well beyond the roughly 80 us the scans take
  initial begin
    #500000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [2:0] cap;
    logic [63:0] din;
    logic [63:0] dout;
    logic [63:0] e;
    logic q[$];
    logic [2:0] codes[6];
    seed_v = $urandom(32'h5b894c92);
    codes = '{3'h3, 3'h4, 3'h7, 3'h5, 3'h6, 3'h2};
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    m_ir = scan_pkg::OP_IDCODE;
    check(64'(id_l), 64'(ID));
    check(64'(tdo_oe_n), 64'h1);
    check_pins();
    end_test("reset");
    // controller sits in logic reset after power-up; scans start from idle
    tester.tap_reset();
    // identification out lsb first, then the shifted word latched
    tester.ir_scan(scan_pkg::OP_IDCODE, cap);
    check(64'(cap), 64'(scan_pkg::IR_CAPTURE_VAL));
    din = 64'($urandom);
    tester.dr_scan(32, din, dout, 1'b0);
    check(dout, 64'(ID));
    check(64'(id_l), din);
    end_test("identification");
    // boundary capture and drive; outputs hold while parked mid-scan
    m_ir = scan_pkg::OP_EXTEST;
    tester.ir_scan(scan_pkg::OP_EXTEST, cap);
    for (int r = 0; r < 2; r++) begin
      pin_obs = 46'({$urandom, $urandom});
      din = {$urandom, $urandom};
      tester.dr_scan(46, din, dout, r == 1);
      check(dout, 64'(pin_obs));
      // a completed scan has already updated the latches; a parked one has not
      if (r == 0) begin
        m_bsr = din[45:0];
      end
      check_pins();
      if (r == 1) begin
        tester.resume();
      end
      m_bsr = din[45:0];
      check_pins();
    end
    end_test("boundary");
    // remaining codes: sample captures pins; the others' bypass path delays by one stage after a captured zero
    foreach (codes[k]) begin
      m_ir = codes[k];
      pin_obs = 46'({$urandom, $urandom});
      din = {$urandom, $urandom};
      tester.ir_scan(codes[k], cap);
      if (codes[k] == scan_pkg::OP_SAMPLE) begin
        tester.dr_scan(46, din, dout, 1'b0);
        check(dout, 64'(pin_obs));
        m_bsr = din[45:0];
      end else begin
        e = '0;
        q = {1'b0};
        for (int i = 0; i < 8; i++) begin
          q.push_back(din[i]);
          e[i] = q.pop_front();
        end
        tester.dr_scan(8, din, dout, 1'b0);
        check(dout, e);
      end
      check_pins();
      end_test("instruction");
    end
    // logic reset by mode select selects identification again
    tester.tap_reset();
    m_ir = scan_pkg::OP_IDCODE;
    tester.dr_scan(32, 64'($urandom), dout, 1'b0);
    check(dout, 64'(ID));
    check(64'(tdo_oe_n), 64'h1);
    end_test("logic reset");
    finish_test();
  end
endmodule // tb_top
